/* hw/mic_pkg.sv */
// Constants, types and register map of the interrupt controller
//
// Behaviour
// [RQ1] Global enable passes unmasked requests, else blocks
// [RQ2] Every reset clears the global enable
// [RQ3] Return from handler sets global enable again
// [RQ4] Service clears enable, pushes, loads fixed vector
// [RQ5] External events vector after three or four cycles
// [RQ6] Latency independent of instruction length
// [RQ7] Flags set regardless of any enable
// [RQ8] Cleared global enable leaves requests pending
// [RQ9] Software clears serviced flags before re-enabling
// [RQ10] Edge pin polarity chosen by select bit
// [RQ11] Valid edge sets flag, enable gates request
// [RQ12] Enabled edge wakes from sleep; enable decides vector
// [RQ13] Timer wrap from max to zero sets flag
// [RQ14] Selected port pin change sets change flag
// [RQ15] Change during port read may be missed
// [RQ16] Active display function disables edge interrupt
// [RQ17] Entry saves only return address; software saves rest
// [RQ18] Core register layout and reset value
// [RQ19] First peripheral flag and enable layout
// [RQ20] Second peripheral registers, unimplemented bits zero
// [RQ21] Wake with enable: next instruction, then vector
// [RQ22] Wake happens whatever the global enable
// [RQ23] Pending enabled source at sleep wakes at once
// [RQ24] Request needs flag and enable, plus group
// [RQ25] Flags readable, writable, cleared by writing zero
package mic_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CORE = 8'h00;
  localparam logic [7:0] OFF_PFLAG_ONE = 8'h01;
  localparam logic [7:0] OFF_PFLAG_TWO = 8'h02;
  localparam logic [7:0] OFF_PEN_ONE = 8'h03;
  localparam logic [7:0] OFF_PEN_TWO = 8'h04;
  localparam logic [7:0] OFF_PIN_SELECT = 8'h05;
  localparam logic [7:0] OFF_EDGE_CTRL = 8'h06;

  // ----------------------------------------------------------------
  // Core register fields, plus the polarity bit of the edge control register
  // ----------------------------------------------------------------
  localparam int BIT_GLOBAL = 7;
  localparam int BIT_GROUP = 6;
  localparam int BIT_TIMER_EN = 5;
  localparam int BIT_EDGE_EN = 4;
  localparam int BIT_CHANGE_EN = 3;
  localparam int BIT_TIMER_FLAG = 2;
  localparam int BIT_EDGE_FLAG = 1;
  localparam int BIT_CHANGE_FLAG = 0;
  localparam int BIT_POLARITY = 0;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CORE = 8'h00;
  localparam logic [7:0] RST_PERIPH = 8'h00;
  localparam logic [7:0] RST_PIN_SELECT = 8'h00;
  localparam logic [7:0] RST_EDGE_CTRL = 8'h01;
  localparam logic [7:0] PTWO_IMPL_MASK = 8'hf5;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // ----------------------------------------------------------------
  // Sequencing constants
  // ----------------------------------------------------------------
  localparam logic [12:0] VECTOR_ADDR = 13'h0004;
  localparam logic [1:0] LAST_LAT_TICK = 2'h2;
  localparam logic [7:0] TIMER_MAX = 8'hff;
  localparam logic [7:0] TIMER_WRAP = 8'h00;

  typedef enum logic [1:0] {MIC_RUN, MIC_SLEEP, MIC_WAKE} mic_state_e;

  // Strobes from the core sequencer, one clock each
  typedef struct packed {
    logic tick;
    logic sleep_exec;
    logic return_exec;
    logic port_read;
  } mic_core_req_s;

  // Answers to the core sequencer
  typedef struct packed {
    logic vector;
    logic push;
    logic wake;
    logic sleeping;
    logic pending;
  } mic_core_ans_s;

endpackage

/* hw/mic_controller.sv */
// Interrupt controller: flags, masks, vectoring and sleep wake-up
`timescale 1ns/1ps
`default_nettype none
module mic_controller
  import mic_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire mic_core_req_s core_req_in,
  output mic_core_ans_s core_ans_out,
  output logic [12:0] vector_addr_out,
  input wire logic edge_pin_in,
  input wire logic display_on_edge_pin_in,
  input wire logic [7:0] port_pins_in,
  input wire logic [7:0] timer_zero_count_in,
  input wire logic [7:0] periph_one_events_in,
  input wire logic [7:0] periph_two_events_in
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] core_interrupt_control;
  logic [7:0] peripheral_flags_one;
  logic [7:0] peripheral_flags_two;
  logic [7:0] peripheral_enables_one;
  logic [7:0] peripheral_enables_two;
  logic [7:0] pin_change_select;
  logic [7:0] edge_control;
  logic edge_prev;
  logic [7:0] port_prev;
  logic [7:0] timer_prev;
  logic [1:0] lat_cnt;
  mic_state_e state;

  logic global_irq_enable;
  logic edge_polarity_select;
  logic edge_hit;
  logic change_hit;
  logic timer_hit;
  logic [7:0] core_events;
  logic core_req;
  logic periph_req;
  logic source_ready;
  logic request;
  logic launch;
  logic wake_now;
  logic wake_vector;
  logic wr_core;

  assign global_irq_enable = core_interrupt_control[BIT_GLOBAL];
  assign edge_polarity_select = edge_control[BIT_POLARITY];
  assign wr_core = enable_in && wr_in && (addr_in == OFF_CORE);

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  // Display function owns the pin, so its toggling must not count
  assign edge_hit = !display_on_edge_pin_in && (edge_pin_in != edge_prev) &&
                    (edge_pin_in == edge_polarity_select); // [RQ10] [RQ16]
  // A read in the same cycle reloads the compare latch; the change may be lost
  assign change_hit = !core_req_in.port_read &&
                      (|((port_pins_in ^ port_prev) & pin_change_select)); // [RQ14] [RQ15]
  assign timer_hit = (timer_prev == TIMER_MAX) && (timer_zero_count_in == TIMER_WRAP); // [RQ13]

  always_comb begin
    core_events = 8'h00;
    core_events[BIT_TIMER_FLAG] = timer_hit;
    core_events[BIT_EDGE_FLAG] = edge_hit; // [RQ11]
    core_events[BIT_CHANGE_FLAG] = change_hit;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      // Track the pins through reset, so release shows no false edge
      edge_prev <= edge_pin_in;
      port_prev <= port_pins_in;
      timer_prev <= timer_zero_count_in;
    end else if (enable_in) begin
      edge_prev <= edge_pin_in;
      port_prev <= port_pins_in;
      timer_prev <= timer_zero_count_in;
    end
  end

  // ----------------------------------------------------------------
  // Request logic
  // ----------------------------------------------------------------
  assign core_req = |(core_interrupt_control[BIT_TIMER_EN:BIT_CHANGE_EN] &
                      core_interrupt_control[BIT_TIMER_FLAG:BIT_CHANGE_FLAG]); // [RQ24] [RQ11]
  assign periph_req = core_interrupt_control[BIT_GROUP] &&
                      (|(peripheral_flags_one & peripheral_enables_one) ||
                       |(peripheral_flags_two & peripheral_enables_two)); // [RQ24]
  assign source_ready = core_req || periph_req;
  // Flags stay set while blocked, so the request simply reappears later
  assign request = global_irq_enable && source_ready; // [RQ1] [RQ8]
  // Counts instruction cycles, not instructions, so two-cycle ops cost nothing extra
  assign launch = (state == MIC_RUN) && request && !core_req_in.return_exec &&
                  core_req_in.tick && (lat_cnt == LAST_LAT_TICK); // [RQ5] [RQ6]
  assign wake_now = source_ready || (|(core_interrupt_control[BIT_TIMER_EN:BIT_CHANGE_EN] &
                    core_events[BIT_TIMER_FLAG:BIT_CHANGE_FLAG])); // [RQ22] [RQ12]
  // A return in the same cycle keeps the enable set, so no vector then
  assign wake_vector = (state == MIC_WAKE) && core_req_in.tick && request &&
                       !core_req_in.return_exec; // [RQ21]

  // ----------------------------------------------------------------
  // Core interrupt control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      core_interrupt_control <= RST_CORE; // [RQ2] [RQ18]
    end else if (enable_in) begin
      if (wr_core) begin
        core_interrupt_control <= wdata_in | core_events; // [RQ25] [RQ7]
      end else begin
        core_interrupt_control <= core_interrupt_control | core_events; // [RQ7]
      end
      if (core_req_in.return_exec) begin
        core_interrupt_control[BIT_GLOBAL] <= 1'b1; // [RQ3]
      end else if (launch || wake_vector) begin
        core_interrupt_control[BIT_GLOBAL] <= 1'b0; // [RQ4]
      end
    end
  end

  // ----------------------------------------------------------------
  // Peripheral registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      peripheral_flags_one <= RST_PERIPH; // [RQ19]
      peripheral_flags_two <= RST_PERIPH; // [RQ20]
    end else if (enable_in) begin
      // Set wins over a clearing write in the same cycle
      if (wr_in && addr_in == OFF_PFLAG_ONE) begin
        peripheral_flags_one <= wdata_in | periph_one_events_in; // [RQ25] [RQ7]
      end else begin
        peripheral_flags_one <= peripheral_flags_one | periph_one_events_in; // [RQ7]
      end
      if (wr_in && addr_in == OFF_PFLAG_TWO) begin
        peripheral_flags_two <= (wdata_in | periph_two_events_in) & PTWO_IMPL_MASK; // [RQ20] [RQ25]
      end else begin
        peripheral_flags_two <= (peripheral_flags_two | periph_two_events_in) & PTWO_IMPL_MASK; // [RQ20]
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      peripheral_enables_one <= RST_PERIPH;
      peripheral_enables_two <= RST_PERIPH;
      pin_change_select <= RST_PIN_SELECT;
      edge_control <= RST_EDGE_CTRL;
    end else if (enable_in && wr_in) begin
      case (addr_in)
        OFF_PEN_ONE: begin
          peripheral_enables_one <= wdata_in; // [RQ19]
        end
        OFF_PEN_TWO: begin
          peripheral_enables_two <= wdata_in & PTWO_IMPL_MASK; // [RQ20]
        end
        OFF_PIN_SELECT: begin
          pin_change_select <= wdata_in; // [RQ14]
        end
        OFF_EDGE_CTRL: begin
          edge_control <= wdata_in & 8'h01;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_out <= READ_IDLE;
    end else if (enable_in) begin
      if (rd_in) begin
        case (addr_in)
          OFF_CORE: rdata_out <= core_interrupt_control; // [RQ25]
          OFF_PFLAG_ONE: rdata_out <= peripheral_flags_one;
          OFF_PFLAG_TWO: rdata_out <= peripheral_flags_two;
          OFF_PEN_ONE: rdata_out <= peripheral_enables_one;
          OFF_PEN_TWO: rdata_out <= peripheral_enables_two;
          OFF_PIN_SELECT: rdata_out <= pin_change_select;
          OFF_EDGE_CTRL: rdata_out <= edge_control;
          default: rdata_out <= READ_IDLE;
        endcase
      end else begin
        rdata_out <= READ_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Latency counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      lat_cnt <= 2'h0;
    end else if (enable_in) begin
      if (state != MIC_RUN || !request || core_req_in.return_exec || launch) begin
        lat_cnt <= 2'h0; // [RQ8]
      end else if (core_req_in.tick) begin
        lat_cnt <= lat_cnt + 2'h1; // [RQ5]
      end
    end
  end

  // ----------------------------------------------------------------
  // Sleep sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= MIC_RUN;
    end else if (enable_in) begin
      case (state)
        MIC_RUN: begin
          if (core_req_in.sleep_exec) begin
            // A source already armed skips sleep entirely
            state <= source_ready ? MIC_WAKE : MIC_SLEEP; // [RQ23]
          end
        end
        MIC_SLEEP: begin
          if (wake_now) begin
            state <= MIC_WAKE; // [RQ22] [RQ12]
          end
        end
        MIC_WAKE: begin
          if (core_req_in.tick) begin
            state <= MIC_RUN; // [RQ21]
          end
        end
        default: begin
          state <= MIC_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Answers to the core
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      core_ans_out <= '0;
      vector_addr_out <= VECTOR_ADDR;
    end else if (enable_in) begin
      // Only the return address is pushed; working and status stay with software
      core_ans_out.vector <= launch || wake_vector; // [RQ4] [RQ21]
      core_ans_out.push <= launch || wake_vector; // [RQ17]
      core_ans_out.wake <= (state == MIC_SLEEP && wake_now) ||
                           (state == MIC_RUN && core_req_in.sleep_exec && source_ready); // [RQ22] [RQ23]
      core_ans_out.sleeping <= (state == MIC_SLEEP) ? !wake_now :
                               (state == MIC_RUN && core_req_in.sleep_exec && !source_ready);
      core_ans_out.pending <= request; // [RQ1]
      vector_addr_out <= VECTOR_ADDR; // [RQ4]
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_reset_clears_gie: assert property (@(posedge clk_in) disable iff (1'b0)
    reset_in |=> !core_interrupt_control[BIT_GLOBAL]) else $error("global enable not cleared by reset"); // [RQ2]
  a_vector_needs_gie: assert property (core_ans_out.vector |-> $past(global_irq_enable) && $past(source_ready))
    else $error("vector without enabled request"); // [RQ1]
  a_vector_clears_gie: assert property (core_ans_out.vector |-> !global_irq_enable && core_ans_out.push)
    else $error("service did not clear enable or push"); // [RQ4]
  a_return_sets_gie: assert property (enable_in && core_req_in.return_exec |=> global_irq_enable)
    else $error("return did not set global enable"); // [RQ3]
  a_latency_three_ticks: assert property (launch |-> lat_cnt == 2'h2 && core_req_in.tick)
    else $error("vector before third instruction cycle"); // [RQ5]
  a_edge_sets_flag: assert property (enable_in && edge_hit |=> core_interrupt_control[BIT_EDGE_FLAG])
    else $error("edge flag missed"); // [RQ10]
  a_timer_sets_flag: assert property (enable_in && timer_hit |=> core_interrupt_control[BIT_TIMER_FLAG])
    else $error("timer flag missed"); // [RQ13]
  a_unimpl_bits_zero: assert property ((peripheral_flags_two & ~PTWO_IMPL_MASK) == 8'h00)
    else $error("unimplemented flag bit set"); // [RQ20]
  a_sleep_wakes: assert property (enable_in && state == MIC_SLEEP && wake_now |=> core_ans_out.wake ##1
    !core_ans_out.sleeping) else $error("armed source did not wake"); // [RQ22]
  a_armed_sleep_skip: assert property (enable_in && state == MIC_RUN && core_req_in.sleep_exec && source_ready
    |=> state == MIC_WAKE && !core_ans_out.sleeping) else $error("sleep entered with armed source"); // [RQ23]

endmodule
`default_nettype wire

/* tb/mic_core_model.sv */
// Core sequencer model: instruction ticks, strobes and return stack
`timescale 1ns/1ps
`default_nettype none
module mic_core_model
  import mic_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [2:0] tick_gap_in,
  input wire logic sleep_cmd_in,
  input wire logic return_cmd_in,
  input wire logic read_cmd_in,
  input wire mic_core_ans_s core_ans_in,
  output mic_core_req_s core_req_out,
  output logic [3:0] depth_out
);
  logic [2:0] gap_count;
  logic last_slot;
  assign last_slot = (gap_count == tick_gap_in - 3'h1);
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Ticks stop while asleep, since no core clock runs then
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      core_req_out <= '0;
      gap_count <= 3'h0;
      depth_out <= 4'h0;
    end else begin
      core_req_out.sleep_exec <= sleep_cmd_in;
      core_req_out.return_exec <= return_cmd_in;
      core_req_out.port_read <= read_cmd_in;
      core_req_out.tick <= !core_ans_in.sleeping && last_slot;
      gap_count <= (core_ans_in.sleeping || last_slot) ? 3'h0 : gap_count + 3'h1;
      // Only the return address is stacked; context is software's job
      if (core_ans_in.push) begin
        depth_out <= depth_out + 4'h1;
      end else if (return_cmd_in) begin
        depth_out <= depth_out - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module testbench
  import mic_pkg::*;
;
  logic clk_in, reset_in, wr_in, rd_in, edge_pin, display_on, sleep_cmd, return_cmd, read_cmd, enable;
  logic [7:0] addr_in, wdata_in, rdata, port_pins, timer_count, ev_one, ev_two;
  logic [2:0] tick_gap;
  logic [12:0] vaddr;
  logic [3:0] depth;
  mic_core_req_s req;
  mic_core_ans_s ans;
  int mismatches, samples_checked;
  localparam int NROWS = 8;
  logic [23:0] rows [NROWS] = '{{OFF_PFLAG_ONE, 8'ha5, 8'ha5}, {OFF_PEN_ONE, 8'h5a, 8'h5a},
    {OFF_PFLAG_TWO, 8'hff, 8'hf5}, {OFF_PEN_TWO, 8'hff, 8'hf5}, {OFF_PIN_SELECT, 8'h3c, 8'h3c},
    {OFF_EDGE_CTRL, 8'hff, 8'h01}, {8'h07, 8'hff, 8'h00}, {OFF_CORE, 8'h07, 8'h07}};

  mic_controller mic_controller_i (.clk_in(clk_in), .reset_in(reset_in), .enable_in(enable),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
    .core_req_in(req), .core_ans_out(ans), .vector_addr_out(vaddr), .edge_pin_in(edge_pin),
    .display_on_edge_pin_in(display_on), .port_pins_in(port_pins), .timer_zero_count_in(timer_count),
    .periph_one_events_in(ev_one), .periph_two_events_in(ev_two));
  mic_core_model mic_core_model_i (.clk_in(clk_in), .reset_in(reset_in), .tick_gap_in(tick_gap),
    .sleep_cmd_in(sleep_cmd), .return_cmd_in(return_cmd), .read_cmd_in(read_cmd), .core_ans_in(ans),
    .core_req_out(req), .depth_out(depth));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    check(name, exp, rdata);
    // Hand back on a rising edge, so callers drive inputs there
    @(posedge clk_in);
  endtask
  // Counts ticks until vector (which 0) or wake (which 1); -1 if none
  task automatic waitfor(input int which, input int lim, output int t);
    t = 0;
    for (int i = 0; i < lim; i++) begin
      @(negedge clk_in);
      if ((which == 0 ? ans.vector : ans.wake) === 1'b1) return;
      if (req.tick === 1'b1) t++;
    end
    t = -1;
  endtask
  task automatic sleep_pulse();
    cyc(1);
    sleep_cmd <= 1'b1;
    cyc(1);
    sleep_cmd <= 1'b0;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  // Whole run needs under 2000 cycles; ten times that means a hang
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    reset_in = 1'b1;
    {wr_in, rd_in, edge_pin, display_on, sleep_cmd, return_cmd, read_cmd} = 7'h00;
    enable = 1'b1;
    {addr_in, wdata_in, port_pins, timer_count, ev_one, ev_two} = '0;
    tick_gap = 3'h2;
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rdchk(i[7:0], (i == 6) ? RST_EDGE_CTRL : RST_CORE, "reset value");
    end
    for (int i = 0; i < NROWS; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rdchk(rows[i][23:16], rows[i][7:0], "register access");
    end
    for (int i = 0; i < 5; i++) wr(i[7:0], 8'h00);
    // Timer wrap with short and long instructions
    for (int g = 2; g < 4; g++) begin
      tick_gap <= g[2:0];
      wr(OFF_CORE, 8'ha0);
      timer_count <= TIMER_MAX;
      cyc(1);
      timer_count <= TIMER_WRAP;
      waitfor(0, 40, n);
      check("entry ticks", 1'b1, n == 3 || n == 4);
      check("vector address", VECTOR_ADDR, vaddr);
      rdchk(OFF_CORE, 8'h24, "entry clears enable");
      check("stack depth", 4'h1, depth);
      waitfor(0, 30, n);
      check("held while disabled", 1'b1, n == -1);
      wr(OFF_CORE, 8'h20);
      return_cmd <= 1'b1;
      cyc(1);
      return_cmd <= 1'b0;
      rdchk(OFF_CORE, 8'ha0, "return restores enable");
      check("stack depth", 4'h0, depth);
    end
    // Peripheral flags and group gate
    wr(OFF_CORE, 8'h80);
    ev_one <= 8'hff;
    ev_two <= 8'hff;
    cyc(1);
    ev_one <= 8'h00;
    ev_two <= 8'h00;
    rdchk(OFF_PFLAG_ONE, 8'hff, "flags one set");
    rdchk(OFF_PFLAG_TWO, 8'hf5, "flags two set");
    wr(OFF_PEN_ONE, 8'h01);
    waitfor(0, 30, n);
    check("group gate", 1'b1, n == -1);
    check("pending while gated", 1'b0, ans.pending);
    wr(OFF_CORE, 8'hc0);
    waitfor(0, 30, n);
    check("group request taken", 1'b1, n != -1);
    check("pending at entry", 1'b1, ans.pending);
    for (int i = 0; i < 5; i++) wr(i[7:0], 8'h00);
    // Edge pin, both polarities, then masked by display use
    for (int p = 0; p < 2; p++) begin
      wr(OFF_EDGE_CTRL, {7'h00, p[0]});
      edge_pin <= p[0];
      wr(OFF_CORE, 8'h00);
      edge_pin <= ~p[0];
      cyc(3);
      rdchk(OFF_CORE, 8'h00, "wrong edge ignored");
      edge_pin <= p[0];
      cyc(3);
      rdchk(OFF_CORE, 8'h02, "valid edge flag");
    end
    display_on <= 1'b1;
    edge_pin <= 1'b0;
    wr(OFF_CORE, 8'h00);
    edge_pin <= 1'b1;
    cyc(3);
    rdchk(OFF_CORE, 8'h00, "display blocks edge");
    display_on <= 1'b0;
    // Port change on selected pins only
    wr(OFF_PIN_SELECT, 8'h01);
    port_pins <= 8'h02;
    cyc(3);
    rdchk(OFF_CORE, 8'h00, "unselected pin");
    port_pins <= 8'h03;
    cyc(3);
    rdchk(OFF_CORE, 8'h01, "selected pin");
    // Sleep and wake
    wr(OFF_CORE, 8'h10);
    sleep_pulse();
    cyc(3);
    @(negedge clk_in);
    check("asleep", 1'b1, ans.sleeping);
    cyc(1);
    edge_pin <= 1'b0;
    cyc(2);
    edge_pin <= 1'b1;
    waitfor(1, 10, n);
    check("edge wakes", 1'b1, n != -1);
    waitfor(0, 20, n);
    check("no vector when disabled", 1'b1, n == -1);
    sleep_pulse();
    waitfor(1, 4, n);
    check("armed source wakes", 1'b1, n != -1);
    wr(OFF_CORE, 8'h90);
    sleep_pulse();
    cyc(3);
    edge_pin <= 1'b0;
    cyc(2);
    edge_pin <= 1'b1;
    waitfor(1, 10, n);
    check("wake with enable", 1'b1, n != -1);
    waitfor(0, 20, n);
    check("vector after next instruction", 1'b1, n == 1);
    // Change landing on a port read is dropped
    wr(OFF_CORE, 8'h00);
    read_cmd <= 1'b1;
    cyc(1);
    read_cmd <= 1'b0;
    port_pins <= 8'h02;
    cyc(3);
    rdchk(OFF_CORE, 8'h00, "change during port read");
    // Clock enable low freezes a write
    enable <= 1'b0;
    wr(OFF_PIN_SELECT, 8'hff);
    enable <= 1'b1;
    rdchk(OFF_PIN_SELECT, 8'h01, "write frozen by enable");
    // Reset in mid-run
    wr(OFF_EDGE_CTRL, 8'h00);
    wr(OFF_CORE, 8'hf8);
    reset_in <= 1'b1;
    cyc(2);
    reset_in <= 1'b0;
    rdchk(OFF_CORE, RST_CORE, "second reset");
    rdchk(OFF_EDGE_CTRL, RST_EDGE_CTRL, "second reset edge");
    results();
  end
endmodule
`default_nettype wire
